// [src/ssc_pkg.sv]
package ssc_pkg;

   // Converter and configuration widths
   localparam int GAIN_W = 5;
   localparam int OFFSET_W = 8;
   localparam int CODE_W = 10;
   localparam int POS_W = 2;
   localparam int CNT_W = 4;
   localparam int NUM_CHAN = 3;

   // Channel indices
   localparam int CHAN_RED = 0;
   localparam int CHAN_GREEN = 1;
   localparam int CHAN_BLUE = 2;

   // Strobe timing, in master clock edges
   localparam int VS_EDGE = 1;
   localparam int RS_EDGE_DEFAULT = 4;
   localparam int CLAMP_DELAY_DEFAULT = 3;
   localparam int POS_MAX = 3;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RS_EDGE_DEFAULT + POS_MAX);
   localparam int CLAMP_PIPE_W = CLAMP_DELAY_DEFAULT + POS_MAX - 1;

   // Code range of the converter
   localparam logic [CODE_W-1:0] CODE_ZERO = 10'h000;
   localparam logic [CODE_W-1:0] CODE_FULL = 10'h3ff;

   // Sampling modes
   typedef enum logic {
      SSC_MODE_CDS,
      SSC_MODE_SINGLE
   } ssc_mode_t;

   // Reset clamp levels; the fourth code is not a level
   typedef enum logic [1:0] {
      SSC_CLAMP_LOW = 2'h0,
      SSC_CLAMP_MID = 2'h1,
      SSC_CLAMP_HIGH = 2'h2
   } ssc_clamp_t;
   localparam logic [1:0] CLAMP_CODE_BAD = 2'h3;

   // Values after reset
   localparam logic [GAIN_W-1:0] GAIN_RESET = 5'h00;
   localparam logic [OFFSET_W-1:0] OFFSET_RESET = 8'h00;
   localparam logic SIGN_RESET = 1'b0;
   localparam logic [POS_W-1:0] POS_RESET = 2'h0;
   localparam ssc_mode_t MODE_RESET = SSC_MODE_CDS;
   localparam ssc_clamp_t CLAMP_RESET = SSC_CLAMP_MID;
   localparam logic INVERT_RESET = 1'b0;
   localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

endpackage

// [src/ssc_pin_sync.sv]
`timescale 1ns/10ps

// Three-stage pin synchroniser; level moves once stages two and three agree
module ssc_pin_sync #(
   parameter logic IDLE = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   output logic level
);
   import ssc_pkg::*;

   logic stage1_q, stage2_q, stage3_q, level_q;
   logic level_d;

   always_comb
   begin
      level_d = level_q;
      if (stage2_q == stage3_q)
      begin
         level_d = stage3_q;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stage1_q <= IDLE;
         stage2_q <= IDLE;
         stage3_q <= IDLE;
         level_q <= IDLE;
      end
      else
      begin
         stage1_q <= pin;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
         level_q <= level_d;
      end
   end

   assign level = level_q;

endmodule

// [src/ssc_chan_cfg.sv]
`timescale 1ns/10ps

// Gain and signed offset settings of one input channel
module ssc_chan_cfg (
   input wire logic clk,
   input wire logic clear,
   input wire logic gainWr,
   input wire logic [ssc_pkg::GAIN_W-1:0] gainData,
   input wire logic offsetWr,
   input wire logic [ssc_pkg::OFFSET_W-1:0] offsetData,
   input wire logic offsetSignData,
   output logic [ssc_pkg::GAIN_W-1:0] gain,
   output logic [ssc_pkg::OFFSET_W-1:0] offsetMag,
   output logic offsetNeg
);
   import ssc_pkg::*;

   logic [GAIN_W-1:0] gain_q, gain_d;
   logic [OFFSET_W-1:0] mag_q, mag_d;
   logic sign_q, sign_d;

   always_comb
   begin
      gain_d = gain_q;
      mag_d = mag_q;
      sign_d = sign_q;
      if (gainWr)
      begin
         gain_d = gainData;
      end
      if (offsetWr)
      begin
         mag_d = offsetData;
         sign_d = offsetSignData;
      end
   end

   always_ff @(posedge clk)
   begin
      if (clear)
      begin
         gain_q <= GAIN_RESET;
         mag_q <= OFFSET_RESET;
         sign_q <= SIGN_RESET;
      end
      else
      begin
         gain_q <= gain_d;
         mag_q <= mag_d;
         sign_q <= sign_d;
      end
   end

   assign gain = gain_q;
   assign offsetMag = mag_q;
   assign offsetNeg = sign_q;

endmodule

// [src/ssc_sample_clamp_control.sv]
`timescale 1ns/10ps

module ssc_sample_clamp_control (
   input wire logic clk,
   input wire logic rst,
   input wire logic resetLow_n,
   input wire logic sampleSync,
   input wire logic clampRequest,
   input wire logic [ssc_pkg::NUM_CHAN-1:0] gainWr,
   input wire logic [ssc_pkg::GAIN_W-1:0] gainData,
   input wire logic [ssc_pkg::NUM_CHAN-1:0] offsetWr,
   input wire logic [ssc_pkg::OFFSET_W-1:0] offsetData,
   input wire logic offsetSignData,
   input wire logic ctrlWr,
   input wire logic [ssc_pkg::POS_W-1:0] positionData,
   input wire ssc_pkg::ssc_mode_t modeData,
   input wire logic [1:0] clampLevelData,
   input wire logic invertData,
   input wire logic [ssc_pkg::CODE_W-1:0] adcCode,
   output logic resetSampleStrobe,
   output logic videoSampleStrobe,
   output logic clampPulse,
   output logic [ssc_pkg::GAIN_W-1:0] gainRed,
   output logic [ssc_pkg::GAIN_W-1:0] gainGreen,
   output logic [ssc_pkg::GAIN_W-1:0] gainBlue,
   output logic [ssc_pkg::OFFSET_W-1:0] offsetMagRed,
   output logic [ssc_pkg::OFFSET_W-1:0] offsetMagGreen,
   output logic [ssc_pkg::OFFSET_W-1:0] offsetMagBlue,
   output logic offsetNegRed,
   output logic offsetNegGreen,
   output logic offsetNegBlue,
   output logic [ssc_pkg::POS_W-1:0] resetSamplePosition,
   output ssc_pkg::ssc_mode_t sampleMode,
   output ssc_pkg::ssc_clamp_t clampLevel,
   output logic invertOutput,
   output logic [ssc_pkg::CODE_W-1:0] videoCode
);
   import ssc_pkg::*;

   // Pin synchronisers
   logic syncLevel, reqLevel, resetLowLevel;
   logic syncLevelPrev_q, syncEvent;
   logic cfgClear;

   ssc_pin_sync #(.IDLE(1'b0)) u_syncPin (
      .clk(clk),
      .rst(rst),
      .pin(sampleSync),
      .level(syncLevel)
   );

   ssc_pin_sync #(.IDLE(1'b0)) u_reqPin (
      .clk(clk),
      .rst(rst),
      .pin(clampRequest),
      .level(reqLevel)
   );

   ssc_pin_sync #(.IDLE(1'b1)) u_resetPin (
      .clk(clk),
      .rst(rst),
      .pin(resetLow_n),
      .level(resetLowLevel)
   );

   assign syncEvent = syncLevel & ~syncLevelPrev_q;
   assign cfgClear = rst | ~resetLowLevel;

   // Per-channel gain and offset
   logic [GAIN_W-1:0] gainCh [NUM_CHAN];
   logic [OFFSET_W-1:0] magCh [NUM_CHAN];
   logic [NUM_CHAN-1:0] negCh;

   for (genvar ch = 0; ch < NUM_CHAN; ch++)
   begin : g_chan
      ssc_chan_cfg u_cfg (
         .clk(clk),
         .clear(cfgClear),
         .gainWr(gainWr[ch]),
         .gainData(gainData),
         .offsetWr(offsetWr[ch]),
         .offsetData(offsetData),
         .offsetSignData(offsetSignData),
         .gain(gainCh[ch]),
         .offsetMag(magCh[ch]),
         .offsetNeg(negCh[ch])
      );
   end

   assign gainRed = gainCh[CHAN_RED];
   assign gainGreen = gainCh[CHAN_GREEN];
   assign gainBlue = gainCh[CHAN_BLUE];
   assign offsetMagRed = magCh[CHAN_RED];
   assign offsetMagGreen = magCh[CHAN_GREEN];
   assign offsetMagBlue = magCh[CHAN_BLUE];
   assign offsetNegRed = negCh[CHAN_RED];
   assign offsetNegGreen = negCh[CHAN_GREEN];
   assign offsetNegBlue = negCh[CHAN_BLUE];

   // Control settings
   logic [POS_W-1:0] pos_q, pos_d;
   ssc_mode_t mode_q, mode_d;
   ssc_clamp_t level_q, level_d;
   logic invert_q, invert_d;

   always_comb
   begin
      pos_d = pos_q;
      mode_d = mode_q;
      level_d = level_q;
      invert_d = invert_q;
      if (ctrlWr)
      begin
         pos_d = positionData;
         mode_d = modeData;
         invert_d = invertData;
         if (clampLevelData != CLAMP_CODE_BAD)
         begin
            level_d = ssc_clamp_t'(clampLevelData);
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (cfgClear)
      begin
         pos_q <= POS_RESET;
         mode_q <= MODE_RESET;
         level_q <= CLAMP_RESET;
         invert_q <= INVERT_RESET;
      end
      else
      begin
         pos_q <= pos_d;
         mode_q <= mode_d;
         level_q <= level_d;
         invert_q <= invert_d;
      end
   end

   assign resetSamplePosition = pos_q;
   assign sampleMode = mode_q;
   assign clampLevel = level_q;
   assign invertOutput = invert_q;

   // Strobe timing
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic running_q, running_d;
   logic rs_q, rs_d, vs_q, vs_d, cl_q, cl_d;
   logic [CLAMP_PIPE_W-1:0] reqPipe_q, reqPipe_d;
   logic [CNT_W-1:0] rsEdge;
   logic [2:0] clampTap;

   assign rsEdge = CNT_W'(RS_EDGE_DEFAULT) + CNT_W'(pos_q);
   assign clampTap = 3'(CLAMP_DELAY_DEFAULT - 2) + 3'(pos_q);

   always_comb
   begin
      cnt_d = cnt_q;
      running_d = running_q;
      if (syncEvent)
      begin
         cnt_d = CNT_W'(VS_EDGE);
         running_d = 1'b1;
      end
      else if (running_q)
      begin
         if (cnt_q == CNT_LAST)
         begin
            running_d = 1'b0;
         end
         else
         begin
            cnt_d = cnt_q + 4'h1;
         end
      end
      vs_d = syncEvent;
      if (mode_q == SSC_MODE_SINGLE)
      begin
         rs_d = syncEvent;
      end
      else
      begin
         rs_d = running_q && !syncEvent && (cnt_q == rsEdge - 4'h1);
      end
      reqPipe_d = {reqPipe_q[CLAMP_PIPE_W-2:0], reqLevel};
      cl_d = reqPipe_q[clampTap];
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         syncLevelPrev_q <= 1'b0;
         cnt_q <= CNT_RESET;
         running_q <= 1'b0;
         rs_q <= 1'b0;
         vs_q <= 1'b0;
         cl_q <= 1'b0;
         reqPipe_q <= '0;
      end
      else
      begin
         syncLevelPrev_q <= syncLevel;
         cnt_q <= cnt_d;
         running_q <= running_d;
         rs_q <= rs_d;
         vs_q <= vs_d;
         cl_q <= cl_d;
         reqPipe_q <= reqPipe_d;
      end
   end

   assign resetSampleStrobe = rs_q;
   assign videoSampleStrobe = vs_q;
   assign clampPulse = cl_q;

   // Converter code path
   logic [CODE_W-1:0] code_q, code_d;

   always_comb
   begin
      code_d = invert_q ? ~adcCode : adcCode;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         code_q <= CODE_ZERO;
      end
      else
      begin
         code_q <= code_d;
      end
   end

   assign videoCode = code_q;

   // Checks
   a_vs_after_sync: assert property (@(posedge clk) disable iff (rst)
      syncEvent |=> videoSampleStrobe)
      else $error("video strobe missing after sync");

   a_rs_default_edge: assert property (@(posedge clk) disable iff (rst)
      (syncEvent && pos_q == 2'h0 && mode_q == SSC_MODE_CDS && !ctrlWr && !cfgClear)
      ##1 (!syncEvent && !ctrlWr && !cfgClear)[*3] |=> resetSampleStrobe)
      else $error("reset strobe not on fourth edge");

   a_rs_pos_three: assert property (@(posedge clk) disable iff (rst)
      (syncEvent && pos_q == 2'h3 && mode_q == SSC_MODE_CDS && !ctrlWr && !cfgClear)
      ##1 (!syncEvent && !ctrlWr && !cfgClear)[*6] |=> resetSampleStrobe)
      else $error("reset strobe position wrong");

   a_clamp_default: assert property (@(posedge clk) disable iff (rst)
      (reqLevel && pos_q == 2'h0 && !ctrlWr && !cfgClear)
      ##1 (!ctrlWr && !cfgClear)[*2] |=> clampPulse)
      else $error("clamp pulse not three clocks after request");

   a_clamp_follows_rs: assert property (@(posedge clk) disable iff (rst)
      (reqLevel && pos_q == 2'h2 && !ctrlWr && !cfgClear)
      ##1 (!ctrlWr && !cfgClear)[*4] |=> clampPulse)
      else $error("clamp pulse did not move with position");

   a_cds_apart: assert property (@(posedge clk) disable iff (rst)
      ($past(mode_q) == SSC_MODE_CDS) |-> !(videoSampleStrobe && resetSampleStrobe))
      else $error("strobes coincide in double sampling");

   a_single_together: assert property (@(posedge clk) disable iff (rst)
      ($past(mode_q) == SSC_MODE_SINGLE) |-> (resetSampleStrobe == videoSampleStrobe))
      else $error("strobes apart in single-ended mode");

   a_gain_write: assert property (@(posedge clk) disable iff (rst)
      (gainWr[CHAN_GREEN] && !cfgClear) |=> (gainGreen == $past(gainData)
      && (gainRed == $past(gainRed) || $past(gainWr[CHAN_RED]))))
      else $error("gain write not held per channel");

   a_offset_write: assert property (@(posedge clk) disable iff (rst)
      (offsetWr[CHAN_BLUE] && !cfgClear) |=> (offsetMagBlue == $past(offsetData)
      && offsetNegBlue == $past(offsetSignData)))
      else $error("offset write lost");

   a_level_legal: assert property (@(posedge clk) disable iff (rst)
      (ctrlWr && clampLevelData == CLAMP_CODE_BAD && !cfgClear)
      |=> $stable(clampLevel))
      else $error("illegal clamp level taken");

   a_invert_code: assert property (@(posedge clk) disable iff (rst)
      ##1 (invertOutput && $stable(invertOutput)) |=> videoCode == ~$past(adcCode))
      else $error("code not inverted");

   a_clear_defaults: assert property (@(posedge clk) disable iff (rst)
      !resetLowLevel |=> (gainRed == GAIN_RESET && resetSamplePosition == POS_RESET
      && clampLevel == CLAMP_RESET && !invertOutput))
      else $error("configuration not at defaults after reset");

   a_restart_count: assert property (@(posedge clk) disable iff (rst)
      syncEvent |=> (cnt_q == CNT_W'(VS_EDGE) && running_q))
      else $error("counter did not restart on sync");

endmodule

// [testbench/ssc_sensor_model.sv]
`timescale 1ns/10ps

// Sensor timing source: sync bursts, clamp requests, converter codes
module ssc_sensor_model (
   input wire logic clk,
   input wire logic fire,
   input wire logic clampEn,
   output logic sampleSync,
   output logic clampRequest,
   output logic [ssc_pkg::CODE_W-1:0] adcCode
);
   import ssc_pkg::*;
   int left = 0;
   logic half = 1'b0;
   initial
   begin
      sampleSync = 1'b0;
      clampRequest = 1'b0;
      adcCode = CODE_ZERO;
   end
   always @(negedge clk)
   begin
      if (fire)
         left = 3;
      sampleSync <= (left > 0);
      clampRequest <= (left > 0) && clampEn;
      if (left > 0)
         left = left - 1;
      half <= ~half;
      if (half)
         adcCode <= CODE_W'($urandom);
   end
endmodule

// [testbench/ssc_sample_clamp_control_test.sv]
`timescale 1ns/10ps

module ssc_sample_clamp_control_test;
   import ssc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic resetLow_n = 1'b1;
   logic fire = 1'b0;
   logic clampEn = 1'b0;
   logic cfgOn = 1'b1;
   logic sampleSync, clampRequest, ctrlWr, offsetSignData, invertData, eInv;
   logic resetSampleStrobe, videoSampleStrobe, clampPulse, invertOutput;
   logic offsetNegRed, offsetNegGreen, offsetNegBlue;
   logic [NUM_CHAN-1:0] gainWr, offsetWr, eNeg;
   logic [GAIN_W-1:0] gainData, gainRed, gainGreen, gainBlue;
   logic [OFFSET_W-1:0] offsetData, offsetMagRed, offsetMagGreen, offsetMagBlue;
   logic [POS_W-1:0] positionData, resetSamplePosition, ePos;
   logic [1:0] clampLevelData;
   logic [CODE_W-1:0] adcCode, videoCode, seenCode;
   ssc_mode_t modeData, sampleMode, eMode;
   ssc_clamp_t clampLevel, eLvl;
   logic [GAIN_W-1:0] eGain [NUM_CHAN];
   logic [OFFSET_W-1:0] eOff [NUM_CHAN];
   int mismatches = 0;
   int nCompared = 0;
   int vAt, rAt, cAt, nV, nR;

   ssc_sample_clamp_control dut (.clk, .rst, .resetLow_n, .sampleSync, .clampRequest,
      .gainWr, .gainData, .offsetWr, .offsetData, .offsetSignData, .ctrlWr,
      .positionData, .modeData, .clampLevelData, .invertData, .adcCode,
      .resetSampleStrobe, .videoSampleStrobe, .clampPulse, .gainRed, .gainGreen,
      .gainBlue, .offsetMagRed, .offsetMagGreen, .offsetMagBlue, .offsetNegRed,
      .offsetNegGreen, .offsetNegBlue, .resetSamplePosition, .sampleMode,
      .clampLevel, .invertOutput, .videoCode);

   ssc_sensor_model model (.clk, .fire, .clampEn, .sampleSync, .clampRequest, .adcCode);

   initial
   begin
      forever #2 clk = ~clk;
   end

   function automatic int rs_gap(input ssc_mode_t m, input logic [POS_W-1:0] p);
      return (m == SSC_MODE_SINGLE) ? 0 : RS_EDGE_DEFAULT - VS_EDGE + int'(p);
   endfunction

   function automatic int cl_gap(input logic [POS_W-1:0] p);
      return CLAMP_DELAY_DEFAULT - VS_EDGE + int'(p);
   endfunction

   function automatic logic [CODE_W-1:0] exp_code(input logic [CODE_W-1:0] a, input logic v);
      return v ? ~a : a;
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      nCompared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", nCompared, mismatches);
      if (mismatches == 0 && nCompared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic set_defaults();
      for (int i = 0; i < NUM_CHAN; i++)
      begin
         eGain[i] = GAIN_RESET;
         eOff[i] = OFFSET_RESET;
         eNeg[i] = SIGN_RESET;
      end
      ePos = POS_RESET;
      eMode = MODE_RESET;
      eLvl = CLAMP_RESET;
      eInv = INVERT_RESET;
   endtask

   task automatic cfg_check();
      check(gainRed, eGain[CHAN_RED]);
      check(gainGreen, eGain[CHAN_GREEN]);
      check(gainBlue, eGain[CHAN_BLUE]);
      check(offsetMagRed, eOff[CHAN_RED]);
      check(offsetMagGreen, eOff[CHAN_GREEN]);
      check(offsetMagBlue, eOff[CHAN_BLUE]);
      check(offsetNegRed, eNeg[CHAN_RED]);
      check(offsetNegGreen, eNeg[CHAN_GREEN]);
      check(offsetNegBlue, eNeg[CHAN_BLUE]);
      check(resetSamplePosition, ePos);
      check(sampleMode, eMode);
      check(clampLevel, eLvl);
      check(invertOutput, eInv);
   endtask

   task automatic wr_chan(input logic [2:0] ch, input logic [4:0] g, input logic [7:0] o,
      input logic s);
      @(negedge clk);
      gainWr <= ch;
      offsetWr <= ch;
      gainData <= g;
      offsetData <= o;
      offsetSignData <= s;
      @(negedge clk);
      gainWr <= '0;
      offsetWr <= '0;
      for (int i = 0; i < NUM_CHAN; i++)
         if (ch[i] && cfgOn)
         begin
            eGain[i] = g;
            eOff[i] = o;
            eNeg[i] = s;
         end
      #1;
      cfg_check();
   endtask

   task automatic wr_ctrl(input logic [1:0] p, input ssc_mode_t m, input logic [1:0] l,
      input logic v);
      @(negedge clk);
      ctrlWr <= 1'b1;
      positionData <= p;
      modeData <= m;
      clampLevelData <= l;
      invertData <= v;
      @(negedge clk);
      ctrlWr <= 1'b0;
      if (cfgOn)
      begin
         ePos = p;
         eMode = m;
         eInv = v;
         if (l != CLAMP_CODE_BAD)
            eLvl = ssc_clamp_t'(l);
      end
      #1;
      cfg_check();
   endtask

   // One sync burst, a second one at loop step again when again >= 0
   task automatic line_run(input logic cl, input int again);
      vAt = -1;
      rAt = -1;
      cAt = -1;
      nV = 0;
      nR = 0;
      @(negedge clk);
      clampEn <= cl;
      fire <= 1'b1;
      @(negedge clk);
      fire <= 1'b0;
      for (int i = 0; i < 24; i++)
      begin
         @(negedge clk);
         fire <= (i == again);
         #1;
         if (videoSampleStrobe === 1'b1)
         begin
            nV++;
            if (vAt < 0)
               vAt = i;
         end
         if (resetSampleStrobe === 1'b1)
         begin
            nR++;
            if (rAt < 0)
               rAt = i;
         end
         if (clampPulse === 1'b1 && cAt < 0)
            cAt = i;
      end
   endtask

   initial
   begin
      #(4 * 20000);
      mismatches++;
      finish_test();
   end

   initial
   begin
      void'($urandom(67));
      gainWr = '0;
      offsetWr = '0;
      gainData = '0;
      offsetData = '0;
      offsetSignData = 1'b0;
      ctrlWr = 1'b0;
      positionData = '0;
      modeData = SSC_MODE_CDS;
      clampLevelData = '0;
      invertData = 1'b0;
      set_defaults();
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst <= 1'b0;
      repeat (6) @(negedge clk);
      #1;
      cfg_check();
      for (int n = 0; n < 20; n++)
         wr_chan(3'($urandom_range(7, 1)), 5'($urandom), 8'($urandom), 1'($urandom));
      wr_chan(3'b111, 5'h1f, 8'hff, 1'b1);
      for (int p = 0; p < 4; p++)
         for (int m = 0; m < 2; m++)
         begin
            wr_ctrl(2'(p), ssc_mode_t'(m), 2'(p), 1'($urandom));
            line_run(1'b1, -1);
            check(16'(nV), 16'h0001);
            check(16'(nR), 16'h0001);
            check(16'(rAt - vAt), 16'(rs_gap(eMode, ePos)));
            check(16'(cAt - vAt), 16'(cl_gap(ePos)));
         end
      wr_ctrl(2'h3, SSC_MODE_CDS, 2'h0, 1'b0);
      line_run(1'b0, 3);
      check(16'(nV), 16'h0002);
      check(16'(nR), 16'h0001);
      check(16'(rAt - vAt), 16'(5 + rs_gap(eMode, ePos)));
      check(16'(cAt), 16'hffff);
      for (int k = 0; k < 2; k++)
      begin
         wr_ctrl(ePos, eMode, 2'(eLvl), 1'(k));
         repeat (12)
         begin
            seenCode = adcCode;
            @(negedge clk);
            #1;
            check(videoCode, exp_code(seenCode, eInv));
         end
      end
      @(negedge clk);
      resetLow_n <= 1'b0;
      repeat (6) @(negedge clk);
      cfgOn = 1'b0;
      set_defaults();
      #1;
      cfg_check();
      wr_chan(3'b111, 5'h15, 8'h5a, 1'b1);
      @(negedge clk);
      resetLow_n <= 1'b1;
      repeat (6) @(negedge clk);
      cfgOn = 1'b1;
      wr_chan(3'b010, 5'h0a, 8'ha5, 1'b0);
      finish_test();
   end
endmodule
